// ---- design/rsso_map.svh ----
// Constants for the rotate, subtract and sleep datapath
`ifndef RSSO_MAP_SVH
`define RSSO_MAP_SVH
// Register bus offsets
`define RSSO_ADDR_CMD 4'h0
`define RSSO_ADDR_OPA 4'h1
`define RSSO_ADDR_ACC 4'h2
`define RSSO_ADDR_FILE 4'h3
`define RSSO_ADDR_STAT 4'h4
`define RSSO_ADDR_WAKE 4'h5
// Command field positions
`define RSSO_CMD_OP_LSB 0
`define RSSO_CMD_OP_MSB 1
`define RSSO_CMD_DEST_BIT 2
// Op codes
`define RSSO_OP_RLC 2'h0
`define RSSO_OP_RRC 2'h1
`define RSSO_OP_SUBL 2'h2
`define RSSO_OP_SLEEP 2'h3
// Status bit positions
`define RSSO_ST_CARRY 0
`define RSSO_ST_NIBBLE 1
`define RSSO_ST_ZERO 2
`define RSSO_ST_PDOWN 3
`define RSSO_ST_TOUT 4
`define RSSO_ST_ASLEEP 5
// Reset values
`define RSSO_ACC_RST 8'h00
`define RSSO_FILE_RST 8'h00
`define RSSO_PDOWN_RST 1'h1
`define RSSO_TOUT_RST 1'h1
// Watchdog widths
`define RSSO_WD_W 8
`define RSSO_PRE_W 7
`endif

// ---- design/rsso_pkg.sv ----
// Types for the rotate, subtract and sleep datapath
package rsso_pkg;
  typedef enum logic [1:0] {
    OP_RLC = 2'h0,
    OP_RRC = 2'h1,
    OP_SUBL = 2'h2,
    OP_SLEEP = 2'h3
  } rsso_op_t;

  typedef struct packed {
    logic carry;
    logic nibble;
    logic zero;
  } rsso_alu_flags_t;

  typedef struct packed {
    logic [7:0] result;
    rsso_alu_flags_t flags;
  } rsso_alu_out_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'h0,
    ST_ENTER = 2'h1,
    ST_SLEEP = 2'h3
  } rsso_state_t;
endpackage

// ---- design/rsso_alu.sv ----
// Combinational rotate and literal-minus-accumulator unit
`timescale 1ns/10ps
`default_nettype none
module rsso_alu (
  input wire rsso_pkg::rsso_op_t op,
  input wire logic [7:0] fileVal,
  input wire logic [7:0] accVal,
  input wire logic [7:0] literal,
  input wire logic carryIn,
  output rsso_pkg::rsso_alu_out_t aluOut
);
  logic [8:0] diff;
  logic [4:0] nibDiff;

  always_comb begin
    diff = {1'b0, literal} + {1'b0, ~accVal} + 9'h001;
    nibDiff = {1'b0, literal[3:0]} + {1'b0, ~accVal[3:0]} + 5'h01;
    aluOut = '0;
    case (op)
      rsso_pkg::OP_RLC: begin
        aluOut.result = {fileVal[6:0], carryIn};
        aluOut.flags.carry = fileVal[7];
      end
      rsso_pkg::OP_RRC: begin
        aluOut.result = {carryIn, fileVal[7:1]};
        aluOut.flags.carry = fileVal[0];
      end
      rsso_pkg::OP_SUBL: begin
        aluOut.result = diff[7:0];
        aluOut.flags.carry = diff[8];
        aluOut.flags.nibble = nibDiff[4];
        aluOut.flags.zero = (diff[7:0] == 8'h00);
      end
      default: begin
        aluOut.result = 8'h00;
      end
    endcase
  end
endmodule
`default_nettype wire

// ---- design/rsso_core.sv ----
// Rotate, subtract and sleep datapath with register port
// ----------------------------------------
// Functional notes
// ----------------------------------------
// Functional notes
// - Rotate left: old carry into bit 0, old bit 7 becomes carry.
// - Rotate right: old carry into bit 7, old bit 0 becomes carry.
// - Rotate destination 0 writes accumulator, 1 writes the file register.
// - Sleep clears power-down flag and sets timeout flag.
// - Sleep clears watchdog counter and its prescaler.
// - Sleep halts the oscillator until a wake-up event.
// - Subtract writes literal minus accumulator into accumulator.
// - Carry is low when accumulator exceeds literal; nibble carry is low when its low nibble exceeds literal's low nibble.
//
// The address map and strobed register access were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "rsso_map.svh"
module rsso_core (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  input wire logic wakePin,
  output logic oscRun,
  output logic [7:0] watchdogCounter,
  output logic [6:0] watchdogPrescaler
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    rsso_pkg::rsso_state_t fsm;
    logic [7:0] acc;
    logic [7:0] fileReg;
    logic carry;
    logic nibble;
    logic zero;
    logic pdown;
    logic tout;
    logic [7:0] wd;
    logic [6:0] pre;
    logic [7:0] rdata;
    logic wakeS1;
    logic wakeS2;
  } rsso_core_state_t;

  rsso_core_state_t st_r;
  rsso_core_state_t st_nxt;
  rsso_pkg::rsso_alu_out_t aluOut;
  rsso_pkg::rsso_op_t cmdOp;
  logic cmdDest;
  logic cmdGo;

  assign cmdOp = rsso_pkg::rsso_op_t'(regWdata[`RSSO_CMD_OP_MSB:`RSSO_CMD_OP_LSB]);
  assign cmdDest = regWdata[`RSSO_CMD_DEST_BIT];
  // Commands are ignored while asleep; the core cannot fetch then
  assign cmdGo = regWr && (regAddr == `RSSO_ADDR_CMD) && (st_r.fsm == rsso_pkg::ST_RUN);

  rsso_alu u_alu (
    .op(cmdOp),
    .fileVal(st_r.fileReg),
    .accVal(st_r.acc),
    .literal(st_r.fileReg),
    .carryIn(st_r.carry),
    .aluOut(aluOut)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.wakeS1 = wakePin;
    st_nxt.wakeS2 = st_r.wakeS1;
    st_nxt.rdata = 8'h00;
    // Watchdog free-runs only while the oscillator is running
    if (st_r.fsm == rsso_pkg::ST_RUN) begin
      st_nxt.pre = st_r.pre + 7'h01;
      if (st_r.pre == 7'h7F) begin
        st_nxt.wd = st_r.wd + 8'h01;
      end
    end
    if (regRd) begin
      if (regAddr == `RSSO_ADDR_ACC) begin
        st_nxt.rdata = st_r.acc;
      end else if (regAddr == `RSSO_ADDR_FILE) begin
        st_nxt.rdata = st_r.fileReg;
      end else if (regAddr == `RSSO_ADDR_STAT) begin
        st_nxt.rdata = {2'h0, st_r.fsm != rsso_pkg::ST_RUN, st_r.tout, st_r.pdown,
                        st_r.zero, st_r.nibble, st_r.carry};
      end else begin
        st_nxt.rdata = 8'h00;
      end
    end
    if (regWr && st_r.fsm == rsso_pkg::ST_RUN) begin
      if (regAddr == `RSSO_ADDR_ACC) begin
        st_nxt.acc = regWdata;
      end else if (regAddr == `RSSO_ADDR_FILE) begin
        st_nxt.fileReg = regWdata;
      end else if (regAddr == `RSSO_ADDR_STAT) begin
        st_nxt.carry = regWdata[`RSSO_ST_CARRY];
        st_nxt.nibble = regWdata[`RSSO_ST_NIBBLE];
        st_nxt.zero = regWdata[`RSSO_ST_ZERO];
      end
    end
    case (st_r.fsm)
      rsso_pkg::ST_RUN: begin
        if (cmdGo) begin
          case (cmdOp)
            rsso_pkg::OP_RLC, rsso_pkg::OP_RRC: begin
              st_nxt.carry = aluOut.flags.carry;
              if (cmdDest) begin
                st_nxt.fileReg = aluOut.result;
              end else begin
                st_nxt.acc = aluOut.result;
              end
            end
            rsso_pkg::OP_SUBL: begin
              st_nxt.acc = aluOut.result;
              st_nxt.carry = aluOut.flags.carry;
              st_nxt.nibble = aluOut.flags.nibble;
              st_nxt.zero = aluOut.flags.zero;
            end
            default: begin
              st_nxt.pdown = 1'b0;
              st_nxt.tout = 1'b1;
              st_nxt.wd = 8'h00;
              st_nxt.pre = 7'h00;
              st_nxt.fsm = rsso_pkg::ST_ENTER;
            end
          endcase
        end
      end
      rsso_pkg::ST_ENTER: begin
        st_nxt.fsm = rsso_pkg::ST_SLEEP;
      end
      rsso_pkg::ST_SLEEP: begin
        if (st_r.wakeS2 || (regWr && regAddr == `RSSO_ADDR_WAKE)) begin
          st_nxt.fsm = rsso_pkg::ST_RUN;
        end
      end
      default: begin
        st_nxt.fsm = rsso_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '0;
      st_r.fsm <= rsso_pkg::ST_RUN;
      st_r.acc <= `RSSO_ACC_RST;
      st_r.fileReg <= `RSSO_FILE_RST;
      st_r.pdown <= `RSSO_PDOWN_RST;
      st_r.tout <= `RSSO_TOUT_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign regRdata = st_r.rdata;
  assign oscRun = (st_r.fsm == rsso_pkg::ST_RUN) || (st_r.fsm == rsso_pkg::ST_ENTER);
  assign watchdogCounter = st_r.wd;
  assign watchdogPrescaler = st_r.pre;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence seqSleepCmd;
    cmdGo && cmdOp == rsso_pkg::OP_SLEEP;
  endsequence
  // Steps of sleep entry, and wake-up requests as the sleeping state sees them
  sequence seqEnterThenSleep;
    st_r.fsm == rsso_pkg::ST_ENTER ##1 st_r.fsm == rsso_pkg::ST_SLEEP;
  endsequence
  sequence seqPinWake;
    st_r.fsm == rsso_pkg::ST_SLEEP && st_r.wakeS2;
  endsequence
  sequence seqWriteWake;
    st_r.fsm == rsso_pkg::ST_SLEEP && regWr && regAddr == `RSSO_ADDR_WAKE;
  endsequence
  sequence seqStayAsleep;
    st_r.fsm == rsso_pkg::ST_SLEEP && !st_r.wakeS2 && !(regWr && regAddr == `RSSO_ADDR_WAKE);
  endsequence
  sequence seqRotCmd;
    cmdGo && cmdOp inside {rsso_pkg::OP_RLC, rsso_pkg::OP_RRC};
  endsequence
  sequence seqSubCmd;
    cmdGo && cmdOp == rsso_pkg::OP_SUBL;
  endsequence

  AST_RLC_RESULT: assert property (@(posedge core_clk) disable iff (!resetn)
    cmdGo && cmdOp == rsso_pkg::OP_RLC && !cmdDest |=> st_r.acc == {$past(st_r.fileReg[6:0]), $past(st_r.carry)}
      && st_r.carry == $past(st_r.fileReg[7]))
    else $error("rotate left result wrong");
  AST_RRC_RESULT: assert property (@(posedge core_clk) disable iff (!resetn)
    cmdGo && cmdOp == rsso_pkg::OP_RRC && !cmdDest |=> st_r.acc == {$past(st_r.carry), $past(st_r.fileReg[7:1])}
      && st_r.carry == $past(st_r.fileReg[0]))
    else $error("rotate right result wrong");
  AST_ROT_DEST: assert property (@(posedge core_clk) disable iff (!resetn)
    cmdGo && cmdOp inside {rsso_pkg::OP_RLC, rsso_pkg::OP_RRC} && cmdDest |=> st_r.acc == $past(st_r.acc))
    else $error("rotate to file disturbed accumulator");
  AST_SLEEP_FLAGS: assert property (@(posedge core_clk) disable iff (!resetn)
    seqSleepCmd |=> !st_r.pdown && st_r.tout)
    else $error("sleep flags wrong");
  AST_SLEEP_WD: assert property (@(posedge core_clk) disable iff (!resetn)
    seqSleepCmd |=> watchdogCounter == 8'h00 && watchdogPrescaler == 7'h00)
    else $error("watchdog not cleared on sleep");
  AST_SLEEP_OSC: assert property (@(posedge core_clk) disable iff (!resetn)
    seqSleepCmd |=> ##1 !oscRun)
    else $error("oscillator still running in sleep");
  AST_SUBL_RESULT: assert property (@(posedge core_clk) disable iff (!resetn)
    cmdGo && cmdOp == rsso_pkg::OP_SUBL |=> st_r.acc == 8'($past(st_r.fileReg) - $past(st_r.acc)))
    else $error("subtract result wrong");
  AST_SUBL_CARRY: assert property (@(posedge core_clk) disable iff (!resetn)
    cmdGo && cmdOp == rsso_pkg::OP_SUBL |=> st_r.carry == ($past(st_r.acc) <= $past(st_r.fileReg))
      && st_r.nibble == ($past(st_r.acc[3:0]) <= $past(st_r.fileReg[3:0])))
    else $error("subtract carries wrong");
  AST_SUBL_ZERO: assert property (@(posedge core_clk) disable iff (!resetn)
    cmdGo && cmdOp == rsso_pkg::OP_SUBL |=> st_r.zero == ($past(st_r.fileReg) == $past(st_r.acc)))
    else $error("zero flag wrong");

  // ----------------------------------------
  // Sleep and wake checks
  // ----------------------------------------
  AST_SLEEP_STEPS: assert property (@(posedge core_clk) disable iff (!resetn)
    seqSleepCmd |=> seqEnterThenSleep)
    else $error("sleep entry did not pass through enter to sleep");
  AST_SLEEP_FLAGS_HOLD: assert property (@(posedge core_clk) disable iff (!resetn)
    st_r.fsm != rsso_pkg::ST_RUN |-> !st_r.pdown && st_r.tout)
    else $error("status flags changed while asleep");
  // Clock stopped or about to stop, so the watchdog may not count
  AST_SLEEP_WD_FROZEN: assert property (@(posedge core_clk) disable iff (!resetn)
    st_r.fsm != rsso_pkg::ST_RUN |=> $stable(watchdogCounter) && $stable(watchdogPrescaler))
    else $error("watchdog moved while the oscillator was stopped");
  AST_SLEEP_NO_WRITE: assert property (@(posedge core_clk) disable iff (!resetn)
    st_r.fsm != rsso_pkg::ST_RUN |=> $stable(st_r.acc) && $stable(st_r.fileReg) && $stable(st_r.carry))
    else $error("register changed while asleep");
  AST_SLEEP_STAYS: assert property (@(posedge core_clk) disable iff (!resetn)
    seqStayAsleep |=> !oscRun)
    else $error("woke without a wake-up event");
  AST_WAKE_PIN: assert property (@(posedge core_clk) disable iff (!resetn)
    seqPinWake |=> oscRun && st_r.fsm == rsso_pkg::ST_RUN)
    else $error("wake pin did not restart the oscillator");
  AST_WAKE_WRITE: assert property (@(posedge core_clk) disable iff (!resetn)
    seqWriteWake |=> oscRun && st_r.fsm == rsso_pkg::ST_RUN)
    else $error("wake write did not restart the oscillator");
  AST_SLEEP_CMD_ONLY: assert property (@(posedge core_clk) disable iff (!resetn)
    cmdGo && cmdOp != rsso_pkg::OP_SLEEP |=> $stable(st_r.pdown) && $stable(st_r.tout))
    else $error("power flags moved without sleep");
  AST_SLEEP_FROM_RUN: assert property (@(posedge core_clk) disable iff (!resetn)
    st_r.fsm == rsso_pkg::ST_ENTER |-> $past(st_r.fsm) == rsso_pkg::ST_RUN)
    else $error("sleep entry not from running state");
  AST_OSC_ENTER: assert property (@(posedge core_clk) disable iff (!resetn)
    st_r.fsm == rsso_pkg::ST_ENTER |=> !oscRun)
    else $error("oscillator not stopped after sleep entry");
  AST_SLEEP_DATA_KEEP: assert property (@(posedge core_clk) disable iff (!resetn)
    seqSleepCmd |=> $stable(st_r.acc) && $stable(st_r.fileReg)
      && $stable(st_r.carry) && $stable(st_r.nibble) && $stable(st_r.zero))
    else $error("sleep disturbed data or arithmetic flags");

  // ----------------------------------------
  // Operand and flag checks
  // ----------------------------------------
  AST_RLC_TO_FILE: assert property (@(posedge core_clk) disable iff (!resetn)
    cmdGo && cmdOp == rsso_pkg::OP_RLC && cmdDest
      |=> st_r.fileReg == {$past(st_r.fileReg[6:0]), $past(st_r.carry)} && st_r.carry == $past(st_r.fileReg[7]))
    else $error("rotate left into file register wrong");
  AST_RRC_TO_FILE: assert property (@(posedge core_clk) disable iff (!resetn)
    cmdGo && cmdOp == rsso_pkg::OP_RRC && cmdDest
      |=> st_r.fileReg == {$past(st_r.carry), $past(st_r.fileReg[7:1])} && st_r.carry == $past(st_r.fileReg[0]))
    else $error("rotate right into file register wrong");
  AST_ROT_FILE_KEEP: assert property (@(posedge core_clk) disable iff (!resetn)
    cmdGo && cmdOp inside {rsso_pkg::OP_RLC, rsso_pkg::OP_RRC} && !cmdDest |=> $stable(st_r.fileReg))
    else $error("rotate to accumulator disturbed file register");
  AST_ROT_FLAGS_KEEP: assert property (@(posedge core_clk) disable iff (!resetn)
    seqRotCmd |=> $stable(st_r.nibble) && $stable(st_r.zero))
    else $error("rotate touched a flag other than carry");
  AST_SUBL_FILE_KEEP: assert property (@(posedge core_clk) disable iff (!resetn)
    seqSubCmd |=> $stable(st_r.fileReg))
    else $error("subtract disturbed file register");
  AST_SUBL_CARRY_LOW: assert property (@(posedge core_clk) disable iff (!resetn)
    cmdGo && cmdOp == rsso_pkg::OP_SUBL && st_r.acc > st_r.fileReg |=> !st_r.carry)
    else $error("carry set although accumulator exceeded literal");
  AST_SUBL_CARRY_HIGH: assert property (@(posedge core_clk) disable iff (!resetn)
    cmdGo && cmdOp == rsso_pkg::OP_SUBL && !(st_r.acc > st_r.fileReg) |=> st_r.carry)
    else $error("carry clear although literal not exceeded");
  AST_SUBL_NIBBLE_LOW: assert property (@(posedge core_clk) disable iff (!resetn)
    cmdGo && cmdOp == rsso_pkg::OP_SUBL && st_r.acc[3:0] > st_r.fileReg[3:0] |=> !st_r.nibble)
    else $error("nibble carry set although low nibble exceeded");
  AST_SUBL_NIBBLE_HIGH: assert property (@(posedge core_clk) disable iff (!resetn)
    cmdGo && cmdOp == rsso_pkg::OP_SUBL && !(st_r.acc[3:0] > st_r.fileReg[3:0]) |=> st_r.nibble)
    else $error("nibble carry clear although low nibble not exceeded");
  AST_SUBL_ZERO_SET: assert property (@(posedge core_clk) disable iff (!resetn)
    cmdGo && cmdOp == rsso_pkg::OP_SUBL && st_r.acc == st_r.fileReg |=> st_r.zero)
    else $error("zero flag not set on equal operands");
  AST_SUBL_ZERO_CLR: assert property (@(posedge core_clk) disable iff (!resetn)
    cmdGo && cmdOp == rsso_pkg::OP_SUBL && st_r.acc != st_r.fileReg |=> !st_r.zero)
    else $error("zero flag set on unequal operands");
endmodule
`default_nettype wire

// ---- testbench/test_rotate_subtract_sleep_ops.sv ----
// Self-checking bench for the rotate, subtract and sleep datapath
`timescale 1ns/10ps
`default_nettype none
`include "rsso_map.svh"
module test_rotate_subtract_sleep_ops;
  logic core_clk, resetn, regWr, regRd, wakePin, oscRun;
  logic [3:0] regAddr;
  logic [7:0] regWdata, regRdata, watchdogCounter, v, a, f, s, ea;
  logic [6:0] watchdogPrescaler;
  logic [23:0] e;
  logic [1:0] op;
  logic d, pd;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;
  int n;

  rsso_core uut (.core_clk(core_clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .wakePin(wakePin), .oscRun(oscRun),
    .watchdogCounter(watchdogCounter), .watchdogPrescaler(watchdogPrescaler));

  initial begin
    core_clk = 0;
    forever #20 core_clk = ~core_clk;
  end

  // ----------------------------------------
  // Bus tasks and checking
  // ----------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      error_cnt++;
    end
  endtask

  // Strobe dropped with a spare edge, so calls never collide
  task automatic wr(input logic [3:0] ad, input logic [7:0] dt);
    regAddr <= ad;
    regWdata <= dt;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [3:0] ad, output logic [7:0] dt);
    regAddr <= ad;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 dt = regRdata;
    @(posedge core_clk);
  endtask

  function automatic logic [23:0] model(input logic [1:0] o, input logic dd, input logic [7:0] w,
                                        input logic [7:0] fr, input logic [7:0] st);
    logic [7:0] res;
    logic [7:0] ns;
    ns = st;
    res = 8'h00;
    case (o)
      2'h0: {ns[0], res} = {fr, st[0]};
      2'h1: {res, ns[0]} = {st[0], fr};
      default: begin
        res = fr - w;
        ns[0] = w <= fr;
        ns[1] = w[3:0] <= fr[3:0];
        ns[2] = res == 8'h00;
      end
    endcase
    if (o == 2'h2 || !dd) return {res, fr, ns};
    return {w, res, ns};
  endfunction

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Hang guard, well above the expected run length
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    resetn = 1'b0;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 4'h0;
    regWdata = 8'h00;
    wakePin = 1'b0;
    pd = 1'b1;
    void'($urandom(93776));
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    rd(`RSSO_ADDR_STAT, v);
    chk(v, 8'h18);
    #1 chk(regRdata, 8'h00);
    rd(`RSSO_ADDR_OPA, v);
    chk(v, 8'h00);
    rd(4'hF, v);
    chk(v, 8'h00);
    $display("reset test done");
    for (n = 0; n < 200; n++) begin
      a = 8'($urandom);
      f = 8'($urandom);
      s = {5'h00, 3'($urandom)};
      op = 2'($urandom % 3);
      d = 1'($urandom);
      case (n)
        0: {op, d, a, f, s} = {2'h0, 1'b0, 8'h00, 8'hE6, 8'h00};
        1: {op, d, a, f} = {2'h1, 1'b1, 8'h00, 8'h81};
        2: {op, a, f} = {2'h2, 8'h3C, 8'h3C};
        3: {op, a, f} = {2'h2, 8'h01, 8'h10};
        4: {op, a, f} = {2'h2, 8'hFF, 8'h00};
        default: ;
      endcase
      e = model(op, d, a, f, s);
      wr(`RSSO_ADDR_ACC, a);
      wr(`RSSO_ADDR_FILE, f);
      wr(`RSSO_ADDR_STAT, s);
      wr(`RSSO_ADDR_CMD, {5'h00, d, op});
      rd(`RSSO_ADDR_ACC, v);
      chk(v, e[23:16]);
      rd(`RSSO_ADDR_FILE, v);
      chk(v, e[15:8]);
      rd(`RSSO_ADDR_STAT, v);
      chk(v, {3'h0, 1'b1, pd, e[2:0]});
    end
    $display("datapath test done");
    for (n = 0; n < 2; n++) begin
      ea = e[23:16];
      wr(`RSSO_ADDR_CMD, {6'h00, `RSSO_OP_SLEEP});
      pd = 1'b0;
      #1 chk({7'h00, oscRun}, 8'h00);
      repeat (5) @(posedge core_clk);
      #1 chk(watchdogCounter, 8'h00);
      chk({1'b0, watchdogPrescaler}, 8'h00);
      rd(`RSSO_ADDR_STAT, v);
      chk({5'h00, v[5:3]}, 8'h06);
      wr(`RSSO_ADDR_ACC, 8'h5A);
      if (n == 0) wakePin <= 1'b1;
      else wr(`RSSO_ADDR_WAKE, 8'h01);
      repeat (10) @(posedge core_clk);
      wakePin <= 1'b0;
      #1 chk({7'h00, oscRun}, 8'h01);
      rd(`RSSO_ADDR_ACC, v);
      chk(v, ea);
      rd(`RSSO_ADDR_STAT, v);
      chk({5'h00, v[5:3]}, 8'h02);
      $display("sleep test %0d done", n);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
